// ===== logic/lcc_consts.vh
// Purpose: constants for the tunnel control header framer and checker
// Assumes: byte-wide packet streams on one clock
// Notes: field positions are bit indices within the header bytes
`ifndef LCC_CONSTS_VH
`define LCC_CONSTS_VH
`define LCC_HDR_BYTES 12
`define LCC_BYTE0_CTRL 8'hC8
`define LCC_BYTE1_VER 8'h03
`define LCC_T_BIT 7
`define LCC_L_BIT 6
`define LCC_S_BIT 3
`define LCC_VER_MASK 8'h0F
`define LCC_VER_VALUE 4'h3
`define LCC_AVP_HDR_BYTES 10'h006
`define LCC_AVP_M_BIT 7
`define LCC_AVP_H_BIT 6
`define LCC_CRC_POLY 32'h04C11DB7
`define LCC_CRC_INIT 32'hFFFFFFFF
// residue as held by the lsb-first register: the bit-reversed form of C704DD7B
`define LCC_CRC_RESIDUE 32'hDEBB20E3
`define LCC_CRC_BYTES 16'h0004
`define LCC_BASE_VENDOR 16'h0000
`define LCC_REG_CTRL 4'h0
`define LCC_REG_CONNECTION_IDENTIFIER 4'h1
`define LCC_REG_SEQ 4'h2
`define LCC_REG_STATUS 4'h3
`define LCC_REG_LAST 4'h4
`define LCC_REG_VENDOR 4'h5
`define LCC_REG_CNT 4'h6
`endif

// ===== logic/lcc_control_header_checker.v
// Purpose: peer-side framer and checker of tunnel control headers, checksum policy,
//   crc-32 and attribute-value pair parsing
// Assumes: the header checksum sum over ip pseudo-header is supplied by the stream source
//   (txCsumIn / rxCsumOk); this block applies the policy around it
// Notes: software port is address, wdata, write strobe, read strobe, rdata one cycle later
// Notes on behaviour
// - no auth: sender writes computed udp checksum
// - no auth: drop zero or bad checksum
// - auth: zero checksum allowed, not checked
// - data packets: send zero, accept zero
// - ipv6 control: always computed checksum sent
// - ipv6 control: verify every nonzero checksum
// - ipv6 data: optional insert, verify nonzero
// - support trailing ethernet crc-32 field
// - type flag one on control
// - length-present flag set to one
// - sequence-present flag set to one
// - reserved header bits sent zero, ignored
// - version field four bits, value three
// - length counts octets from type flag
// - four-byte connection identifier per connection
// - send and receive sequence numbers sent
// - rejected mandatory attribute tears down connection; code tears down only if the last attribute started is mandatory
// - hidden flag marks encrypted attribute contents
// - attribute reserved bits sent zero, ignored
// - attribute length is value plus six
// - vendor zero base, assigned code otherwise
// - unknown vendor, not mandatory: skip attribute
//
// Decided for this implementation: the register addresses and the strobed register port.
`timescale 1ns/1ps
`include "lcc_consts.vh"
module lcc_control_header_checker #(
  parameter [15:0] OWN_VENDOR = 16'h1234 // arbitrary value, set to the assigned code
) (
  // clock and reset
  input wire clk,
  input wire reset,
  // software port
  input wire [3:0] regAddr,
  input wire [31:0] regWdata,
  input wire regWr,
  input wire regRd,
  output reg [31:0] regRdata,
  // checksum inputs from the pseudo-header adder
  input wire [15:0] txCsumIn,
  input wire rxCsumOk,
  // transmit header stream
  input wire txStart,
  output reg [7:0] txByte,
  output reg txValid,
  output reg [15:0] txCsumOut,
  output reg txCsumValid,
  // receive stream
  input wire [7:0] rxByte,
  input wire rxValid,
  input wire rxLast,
  input wire [15:0] rxCsumField,
  input wire rxIsControl,
  // receive verdict
  output reg rxAccept,
  output reg rxDrop,
  output reg teardown
);
  localparam S_IDLE = 4'b0001;
  localparam S_HDR = 4'b0010;
  localparam S_AVP = 4'b0100;
  localparam S_DONE = 4'b1000;

  // control: [0] udp on, [1] auth on, [2] ipv6, [3] data-csum insert on ipv6, [4] is data
  reg [4:0] ctrl_r;
  reg [31:0] connection_identifier_r;
  reg [31:0] seq_r;
  reg [15:0] txLen_r;
  reg [15:0] vendor_r;
  reg [3:0] txIdx_r;
  reg txBusy_r;
  reg [3:0] st_r;
  reg [3:0] rxIdx_r;
  reg [15:0] rxLen_r;
  reg [15:0] rxCnt_r;
  reg [15:0] avpEnd_r;
  reg [2:0] avpPos_r;
  reg avpMand_r;
  reg [9:0] avpLen_r;
  reg [7:0] avpVhi_r;
  reg badHdr_r;
  reg malformed_r;
  reg skipped_r;
  reg [31:0] crc_r;
  reg [7:0] stat_r;
  reg [15:0] accCnt_r;
  reg [15:0] dropCnt_r;
  wire udpOn = ctrl_r[0];
  wire authOn = ctrl_r[1];
  wire ipv6 = ctrl_r[2];
  wire dataIns = ctrl_r[3];
  wire isData = ctrl_r[4];
  reg [7:0] hdrByte;
  reg [31:0] crcNxt;
  reg csumPass;
  integer i;
  // attribute length and end while its second byte is on the lane
  wire [9:0] avpLenNow = {avpLen_r[9:8], rxByte};
  wire [15:0] avpEndNxt = avpEnd_r + {6'h00, avpLenNow};
  // attributes stop where the crc trailer starts; the trailer is counted in the length
  wire [15:0] bodyEnd = rxLen_r - `LCC_CRC_BYTES;
  reg crcBad;
  reg dropNow;

  // outgoing header bytes; reserved bits zero
  always @* begin
    case (txIdx_r)
      4'h0: hdrByte = `LCC_BYTE0_CTRL;
      4'h1: hdrByte = `LCC_BYTE1_VER;
      4'h2: hdrByte = txLen_r[15:8];
      4'h3: hdrByte = txLen_r[7:0];
      4'h4: hdrByte = connection_identifier_r[31:24];
      4'h5: hdrByte = connection_identifier_r[23:16];
      4'h6: hdrByte = connection_identifier_r[15:8];
      4'h7: hdrByte = connection_identifier_r[7:0];
      4'h8: hdrByte = seq_r[31:24];
      4'h9: hdrByte = seq_r[23:16];
      4'hA: hdrByte = seq_r[15:8];
      4'hB: hdrByte = seq_r[7:0];
      default: hdrByte = 8'h00;
    endcase
  end

  // reflected crc-32, one byte per cycle
  always @* begin
    crcNxt = crc_r;
    for (i = 0; i < 8; i = i + 1) begin
      if (crcNxt[0] ^ rxByte[i])
        crcNxt = (crcNxt >> 1) ^ 32'hEDB88320;
      else
        crcNxt = crcNxt >> 1;
    end
  end

  // checksum policy on receive
  // a zero field only passes where the sender may legally leave the sum out
  always @* begin
    if (!udpOn)
      csumPass = 1'b1;
    else if (!rxIsControl)
      csumPass = (rxCsumField == 16'h0000) || rxCsumOk;
    else if (ipv6)
      csumPass = (rxCsumField != 16'h0000) && rxCsumOk;
    else if (authOn)
      csumPass = (rxCsumField == 16'h0000) || rxCsumOk;
    else
      csumPass = (rxCsumField != 16'h0000) && rxCsumOk;
  end

  // verdict terms; a short packet is dropped even when its crc happens to match
  always @* begin
    crcBad = (crc_r != `LCC_CRC_RESIDUE);
    dropNow = badHdr_r || malformed_r || !csumPass || crcBad || (rxCnt_r < rxLen_r);
  end

  // software port
  // 0 control: [0] udp, [1] auth, [2] ipv6, [3] data checksum on ipv6, [4] data,
  //   [31:16] transmit length; 1 connection identifier; 2 {send, receive} sequence;
  //   3 status; 4 running crc; 5 own vendor code; 6 {drop, accept} counts
  // a read of an unmapped word returns zero and a write there is dropped
  always @(posedge clk) begin
    if (reset) begin
      ctrl_r <= 5'h00;
      connection_identifier_r <= 32'h00000000;
      seq_r <= 32'h00000000;
      txLen_r <= 16'h000C;
      vendor_r <= OWN_VENDOR;
      regRdata <= 32'h00000000;
    end else begin
      if (regWr) begin
        case (regAddr)
          `LCC_REG_CTRL: begin
            ctrl_r <= regWdata[4:0];
            txLen_r <= regWdata[31:16];
          end
          `LCC_REG_CONNECTION_IDENTIFIER: connection_identifier_r <= regWdata;
          `LCC_REG_SEQ: seq_r <= regWdata;
          `LCC_REG_VENDOR: vendor_r <= regWdata[15:0];
          default: ;
        endcase
      end
      if (regRd) begin
        case (regAddr)
          `LCC_REG_CTRL: regRdata <= {txLen_r, 11'h000, ctrl_r};
          `LCC_REG_CONNECTION_IDENTIFIER: regRdata <= connection_identifier_r;
          `LCC_REG_SEQ: regRdata <= seq_r;
          `LCC_REG_STATUS: regRdata <= {24'h000000, stat_r};
          `LCC_REG_LAST: regRdata <= crc_r;
          `LCC_REG_VENDOR: regRdata <= {16'h0000, vendor_r};
          `LCC_REG_CNT: regRdata <= {dropCnt_r, accCnt_r};
          default: regRdata <= 32'h00000000;
        endcase
      end else begin
        regRdata <= 32'h00000000;
      end
    end
  end

  // transmit framer
  always @(posedge clk) begin
    if (reset) begin
      txIdx_r <= 4'h0;
      txBusy_r <= 1'b0;
      txByte <= 8'h00;
      txValid <= 1'b0;
      txCsumOut <= 16'h0000;
      txCsumValid <= 1'b0;
    end else begin
      txCsumValid <= 1'b0;
      if (txStart && !txBusy_r) begin
        txBusy_r <= 1'b1;
        txIdx_r <= 4'h0;
        txCsumValid <= udpOn;
        // a computed zero goes out as all ones, since zero on the wire means no sum
        if (isData && !(ipv6 && dataIns))
          txCsumOut <= 16'h0000;
        else if (!isData && authOn && !ipv6)
          txCsumOut <= 16'h0000;
        else
          txCsumOut <= (txCsumIn == 16'h0000) ? 16'hFFFF : txCsumIn;
      end
      if (txBusy_r) begin
        txByte <= hdrByte;
        txValid <= 1'b1;
        if (txIdx_r == 4'hB)
          txBusy_r <= 1'b0;
        txIdx_r <= txIdx_r + 4'h1;
      end else begin
        txValid <= 1'b0;
      end
    end
  end

  // receive parser
  // rxCnt_r holds the index of the byte on the lane, avpEnd_r that of the next attribute
  always @(posedge clk) begin
    if (reset) begin
      st_r <= S_IDLE;
      rxIdx_r <= 4'h0;
      rxLen_r <= 16'h0000;
      rxCnt_r <= 16'h0000;
      avpEnd_r <= 16'h0000;
      avpPos_r <= 3'h0;
      avpMand_r <= 1'b0;
      avpLen_r <= 10'h000;
      avpVhi_r <= 8'h00;
      badHdr_r <= 1'b0;
      malformed_r <= 1'b0;
      skipped_r <= 1'b0;
      crc_r <= `LCC_CRC_INIT;
      stat_r <= 8'h00;
      accCnt_r <= 16'h0000;
      dropCnt_r <= 16'h0000;
      rxAccept <= 1'b0;
      rxDrop <= 1'b0;
      teardown <= 1'b0;
    end else begin
      rxAccept <= 1'b0;
      rxDrop <= 1'b0;
      teardown <= 1'b0;
      if (rxValid && st_r != S_DONE) begin
        crc_r <= crcNxt;
        rxCnt_r <= rxCnt_r + 16'h0001;
      end
      case (st_r)
        S_IDLE: begin
          if (rxValid) begin
            crc_r <= crcNxt;
            rxCnt_r <= 16'h0001;
            rxIdx_r <= 4'h1;
            skipped_r <= 1'b0;
            malformed_r <= 1'b0;
            badHdr_r <= !(rxByte[`LCC_T_BIT] && rxByte[`LCC_L_BIT] && rxByte[`LCC_S_BIT]);
            st_r <= rxLast ? S_DONE : S_HDR;
          end else begin
            crc_r <= `LCC_CRC_INIT;
          end
        end
        S_HDR: begin
          if (rxValid) begin
            rxIdx_r <= rxIdx_r + 4'h1;
            if (rxIdx_r == 4'h1 && (rxByte & `LCC_VER_MASK) != {4'h0, `LCC_VER_VALUE})
              badHdr_r <= 1'b1;
            if (rxIdx_r == 4'h2)
              rxLen_r[15:8] <= rxByte;
            if (rxIdx_r == 4'h3)
              rxLen_r[7:0] <= rxByte;
            if (rxIdx_r == 4'hB) begin
              avpPos_r <= 3'h0;
              avpEnd_r <= rxCnt_r + 16'h0001;
              st_r <= S_AVP;
            end
            if (rxLast)
              st_r <= S_DONE;
          end
        end
        S_AVP: begin
          if (rxValid) begin
            if (rxCnt_r == avpEnd_r && rxCnt_r < bodyEnd) begin
              // first byte of a new attribute; reserved nibble ignored
              avpMand_r <= rxByte[`LCC_AVP_M_BIT];
              avpLen_r[9:8] <= rxByte[1:0];
              avpPos_r <= 3'h1;
              // hidden contents cannot be decoded here, so a mandatory one is rejected and any other is skipped
              if (rxByte[`LCC_AVP_H_BIT]) begin
                if (rxByte[`LCC_AVP_M_BIT])
                  malformed_r <= 1'b1;
                else
                  skipped_r <= 1'b1;
              end
            end else if (avpPos_r != 3'h0 && avpPos_r < 3'h6) begin
              avpPos_r <= avpPos_r + 3'h1;
              if (avpPos_r == 3'h1) begin
                avpLen_r[7:0] <= rxByte;
                if (avpLenNow < `LCC_AVP_HDR_BYTES || avpEndNxt > bodyEnd)
                  malformed_r <= 1'b1;
                else
                  avpEnd_r <= avpEndNxt;
              end
              if (avpPos_r == 3'h2)
                avpVhi_r <= rxByte;
              if (avpPos_r == 3'h3 && {avpVhi_r, rxByte} != `LCC_BASE_VENDOR &&
                  {avpVhi_r, rxByte} != vendor_r) begin
                if (avpMand_r)
                  malformed_r <= 1'b1;
                else
                  skipped_r <= 1'b1;
              end
            end
            if (rxLast)
              st_r <= S_DONE;
          end
        end
        S_DONE: begin
          // verdict one cycle after the last byte
          // checksum inputs are still held by the source in this cycle
          if (dropNow) begin
            rxDrop <= 1'b1;
            dropCnt_r <= dropCnt_r + 16'h0001;
          end else begin
            rxAccept <= 1'b1;
            accCnt_r <= accCnt_r + 16'h0001;
          end
          teardown <= malformed_r && avpMand_r;
          // status: [4] skipped, [3] checksum fail, [2] crc fail, [1] malformed, [0] header
          stat_r <= {3'h0, skipped_r, !csumPass, crcBad, malformed_r, badHdr_r};
          // fresh seed here, so a packet two cycles behind does not inherit the residue
          crc_r <= `LCC_CRC_INIT;
          st_r <= S_IDLE;
        end
        default: st_r <= S_IDLE;
      endcase
    end
  end
endmodule

// ===== test/lcc_control_header_checker_sva.sv
// Purpose: port checker for the control header block
// Assumes: control register mirrored from software writes
// Notes: attached by the bind at the foot
`timescale 1ns/1ps
module lcc_control_header_checker_sva (
  // clock and software port
  input wire clk,
  input wire reset,
  input wire [3:0] regAddr,
  input wire [31:0] regWdata,
  input wire regWr,
  // streams and verdicts
  input wire [15:0] txCsumIn,
  input wire [7:0] txByte,
  input wire txValid,
  input wire [15:0] txCsumOut,
  input wire txCsumValid,
  input wire rxValid,
  input wire rxLast,
  input wire [15:0] rxCsumField,
  input wire rxIsControl,
  input wire rxAccept,
  input wire rxDrop,
  input wire teardown
);
  reg [4:0] ctrl_r;
  always @(posedge clk) begin
    if (reset)
      ctrl_r <= 5'h00;
    else if (regWr && regAddr == 4'h0)
      ctrl_r <= regWdata[4:0];
  end
  type_byte_a: assert property (@(posedge clk) disable iff (reset)
    $rose(txValid) |-> txByte == 8'hC8) else $error("first header byte wrong");
  version_byte_a: assert property (@(posedge clk) disable iff (reset)
    $rose(txValid) |=> txByte == 8'h03) else $error("version byte wrong");
  hdr_span_a: assert property (@(posedge clk) disable iff (reset)
    $rose(txValid) |-> ##11 txValid ##1 !txValid) else $error("header not 12 bytes");
  csum_lead_a: assert property (@(posedge clk) disable iff (reset)
    txCsumValid |=> $rose(txValid)) else $error("checksum not ahead of header");
  csum_copy_a: assert property (@(posedge clk) disable iff (reset)
    txCsumValid && !ctrl_r[4] && !ctrl_r[1] |->
    txCsumOut == ($past(txCsumIn) == 16'h0000 ? 16'hFFFF : $past(txCsumIn)))
    else $error("control checksum wrong");
  v6_nonzero_a: assert property (@(posedge clk) disable iff (reset)
    txCsumValid && ctrl_r[2] && !ctrl_r[4] |-> txCsumOut != 16'h0000)
    else $error("zero checksum on v6 control");
  data_zero_a: assert property (@(posedge clk) disable iff (reset)
    txCsumValid && ctrl_r[4] && !(ctrl_r[2] && ctrl_r[3]) |-> txCsumOut == 16'h0000)
    else $error("data checksum not zero");
  verdict_time_a: assert property (@(posedge clk) disable iff (reset)
    rxValid && rxLast |-> ##2 (rxAccept != rxDrop)) else $error("verdict missing");
  zero_drop_a: assert property (@(posedge clk) disable iff (reset)
    rxValid && rxLast && rxIsControl && ctrl_r[1:0] == 2'h1 && rxCsumField == 16'h0000
    |-> ##2 rxDrop) else $error("zero checksum accepted");
  teardown_drop_a: assert property (@(posedge clk) disable iff (reset)
    teardown |-> rxDrop) else $error("teardown without drop");
endmodule
bind lcc_control_header_checker lcc_control_header_checker_sva chk (.clk(clk),
  .reset(reset), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
  .txCsumIn(txCsumIn), .txByte(txByte), .txValid(txValid), .txCsumOut(txCsumOut),
  .txCsumValid(txCsumValid), .rxValid(rxValid), .rxLast(rxLast),
  .rxCsumField(rxCsumField), .rxIsControl(rxIsControl), .rxAccept(rxAccept),
  .rxDrop(rxDrop), .teardown(teardown));

// ===== test/lcc_peer_model.sv
// Purpose: far tunnel endpoint sending control and data packets
// Assumes: body holds the attribute bytes set by the bench
// Notes: released byte lane shows the inverse of the last byte
`timescale 1ns/1ps
module lcc_peer_model (
  // clock
  input wire clk,
  // receive stream toward the block
  output reg [7:0] rxByte,
  output reg rxValid,
  output reg rxLast,
  output reg [15:0] rxCsumField,
  output reg rxIsControl,
  output reg rxCsumOk
);
  logic [7:0] body[$];
  initial begin
    rxByte = 8'h00;
    rxValid = 1'b0;
    rxLast = 1'b0;
    rxCsumField = 16'h0000;
    rxIsControl = 1'b0;
    rxCsumOk = 1'b0;
  end
  function automatic [31:0] crcStep(input [31:0] c, input [7:0] b);
    integer n;
    begin
      c = c ^ {24'h000000, b};
      for (n = 0; n < 8; n = n + 1)
        c = c[0] ? (c >> 1) ^ 32'hEDB88320 : c >> 1;
      crcStep = c;
    end
  endfunction
  task sendPkt(input [15:0] cs, input ctl, input ok, input bad);
    logic [7:0] q[$];
    logic [31:0] crc;
    begin
      // length counts header, attributes and trailer
      q = '{8'hC8, 8'h03, 8'h00, 8'(body.size() + 16), 8'h00, 8'h00, 8'h00, 8'h2A,
            8'h00, 8'h01, 8'h00, 8'h00};
      q = {q, body};
      crc = 32'hFFFFFFFF;
      foreach (q[k])
        crc = crcStep(crc, q[k]);
      crc = ~crc ^ {31'h0, bad};
      q = {q, crc[7:0], crc[15:8], crc[23:16], crc[31:24]};
      @(posedge clk);
      rxCsumField <= cs;
      rxIsControl <= ctl;
      rxCsumOk <= ok;
      foreach (q[k]) begin
        rxByte <= q[k];
        rxValid <= 1'b1;
        rxLast <= (k == q.size() - 1);
        @(posedge clk);
      end
      rxByte <= ~q[q.size() - 1];
      rxValid <= 1'b0;
      rxLast <= 1'b0;
    end
  endtask
endmodule

// ===== test/lcc_control_header_checker_tb.sv
// Purpose: self-checking bench for the control header block
// Assumes: checksum adder replaced by bench-driven inputs
// Notes: verdict waits are bounded
`timescale 1ns/1ps
module lcc_control_header_checker_tb;
  reg clk, reset, regWr, regRd, txStart;
  reg [3:0] regAddr;
  reg [31:0] regWdata, rd;
  reg [15:0] txCsumIn;
  wire [31:0] regRdata;
  wire [15:0] txCsumOut, rxCsumField;
  wire [7:0] txByte, rxByte;
  wire txValid, txCsumValid, rxValid, rxLast, rxIsControl, rxCsumOk, rxAccept, rxDrop, teardown;
  integer failCount = 0, numChecks = 0, i;
  lcc_control_header_checker #(.OWN_VENDOR(16'h5A5A)) dut (.clk(clk), .reset(reset),
    .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
    .regRdata(regRdata), .txCsumIn(txCsumIn), .rxCsumOk(rxCsumOk), .txStart(txStart),
    .txByte(txByte), .txValid(txValid), .txCsumOut(txCsumOut), .txCsumValid(txCsumValid),
    .rxByte(rxByte), .rxValid(rxValid), .rxLast(rxLast), .rxCsumField(rxCsumField),
    .rxIsControl(rxIsControl), .rxAccept(rxAccept), .rxDrop(rxDrop), .teardown(teardown));
  lcc_peer_model peer (.clk(clk), .rxByte(rxByte), .rxValid(rxValid), .rxLast(rxLast),
    .rxCsumField(rxCsumField), .rxIsControl(rxIsControl), .rxCsumOk(rxCsumOk));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task summarize;
    begin
      if (failCount == 0 && numChecks > 0)
        $display("ALL TESTS PASSED");
      else
        $display("TESTS FAILED");
      $finish;
    end
  endtask
  task chk(input string nm, input [31:0] exp, input [31:0] got);
    begin
      numChecks = numChecks + 1;
      if (got !== exp) begin
        failCount = failCount + 1;
        $display("[ERR] %s expected %h seen %h", nm, exp, got);
      end
    end
  endtask
  task tick;
    begin
      @(posedge clk);
      #1;
    end
  endtask
  task regWrite(input [3:0] a, input [31:0] d);
    begin
      @(posedge clk);
      regAddr <= a;
      regWdata <= d;
      regWr <= 1'b1;
      @(posedge clk);
      regWr <= 1'b0;
    end
  endtask
  task regRead(input [3:0] a);
    begin
      @(posedge clk);
      regAddr <= a;
      regRd <= 1'b1;
      tick;
      regRd <= 1'b0;
      rd = regRdata;
    end
  endtask
  task tReg;
    begin
      regRead(4'h5);
      chk("vendor", 32'h00005A5A, rd);
      regWrite(4'h1, 32'h12345678);
      regWrite(4'hF, 32'hFFFFFFFF);
      regRead(4'hF);
      chk("unmapped", 32'h00000000, rd);
      regRead(4'h1);
      chk("connection_identifier", 32'h12345678, rd);
    end
  endtask
  task tTx(input [31:0] c, input [15:0] cin, input [15:0] cexp);
    reg [7:0] e [0:11];
    begin
      e = '{8'hC8, 8'h03, c[31:24], c[23:16], 8'hA1, 8'hB2, 8'hC3, 8'hD4, 8'h00, 8'h05,
            8'h00, 8'h09};
      regWrite(4'h0, c);
      regWrite(4'h1, 32'hA1B2C3D4);
      regWrite(4'h2, 32'h00050009);
      @(posedge clk);
      txCsumIn <= cin;
      txStart <= 1'b1;
      @(posedge clk);
      txStart <= 1'b0;
      for (i = 0; i < 6 && txValid !== 1'b1; i = i + 1)
        tick;
      if (i == 6) begin
        failCount = failCount + 1;
        summarize;
      end
      chk("tx csum", {16'h0000, cexp}, {16'h0000, txCsumOut});
      for (i = 0; i < 12; i = i + 1) begin
        if (!c[4])
          chk("hdr byte", {24'h0, e[i]}, {24'h0, txByte});
        // a start in mid-header must be ignored
        txStart <= (i == 3);
        tick;
      end
    end
  endtask
  task tRx(input [4:0] c, input ctl, input [15:0] cs, input ok, input bad, input [7:0] m,
           input [15:0] vd, input [7:0] ln, input acc, input td);
    begin
      regWrite(4'h0, {27'h0, c});
      peer.body = '{m, ln, vd[15:8], vd[7:0], 8'h00, 8'h01, 8'h00, 8'h01};
      peer.sendPkt(cs, ctl, ok, bad);
      for (i = 0; i < 4 && rxAccept !== 1'b1 && rxDrop !== 1'b1; i = i + 1)
        tick;
      if (i == 4) begin
        failCount = failCount + 1;
        summarize;
      end
      chk("accept", {31'h0, acc}, {31'h0, rxAccept});
      chk("drop", {31'h0, !acc}, {31'h0, rxDrop});
      chk("teardown", {31'h0, td}, {31'h0, teardown});
    end
  endtask
  task tCnt(input [31:0] cnt, input [31:0] st);
    begin
      regRead(4'h6);
      chk("counters", cnt, rd);
      regRead(4'h3);
      chk("status", st, rd);
    end
  endtask
  initial begin
    reset = 1'b1;
    regWr = 1'b0;
    regRd = 1'b0;
    txStart = 1'b0;
    regAddr = 4'h0;
    regWdata = 32'h00000000;
    txCsumIn = 16'h0000;
    repeat (4) @(posedge clk);
    reset <= 1'b0;
    tReg;
    tTx(32'h00200001, 16'hBEEF, 16'hBEEF);
    tTx(32'h00200005, 16'h0000, 16'hFFFF);
    tTx(32'h00200011, 16'hBEEF, 16'h0000);
    tRx(5'h01, 1, 16'h1234, 1, 0, 8'h80, 16'h0000, 8'h08, 1, 0);
    tRx(5'h01, 1, 16'h0000, 1, 0, 8'h80, 16'h0000, 8'h08, 0, 0);
    tRx(5'h01, 1, 16'h1234, 0, 0, 8'h80, 16'h0000, 8'h08, 0, 0);
    tRx(5'h03, 1, 16'h0000, 0, 0, 8'h80, 16'h0000, 8'h08, 1, 0);
    tRx(5'h01, 0, 16'h0000, 0, 0, 8'h80, 16'h0000, 8'h08, 1, 0);
    tRx(5'h05, 1, 16'h1234, 0, 0, 8'h80, 16'h0000, 8'h08, 0, 0);
    tRx(5'h05, 0, 16'h1234, 0, 0, 8'h80, 16'h0000, 8'h08, 0, 0);
    tRx(5'h01, 1, 16'h1234, 1, 1, 8'h80, 16'h0000, 8'h08, 0, 0);
    tRx(5'h01, 1, 16'h1234, 1, 0, 8'h00, 16'h7777, 8'h08, 1, 0);
    tRx(5'h01, 1, 16'h1234, 1, 0, 8'h80, 16'h7777, 8'h08, 0, 1);
    tRx(5'h01, 1, 16'h1234, 1, 0, 8'h00, 16'h0000, 8'h04, 0, 0);
    tCnt(32'h00070004, 32'h00000002);
    tRx(5'h01, 1, 16'h1234, 1, 0, 8'hBC, 16'h0000, 8'h08, 1, 0);
    tRx(5'h01, 1, 16'h1234, 1, 0, 8'h40, 16'h0000, 8'h08, 1, 0);
    summarize;
  end
endmodule
